/* core/smbsc_pkg.sv */
// Constants and types for the shutter motor blockage and slat control block.
// Assumes a 10 MHz ref_clk; the reverse, hold and tick times are converted to cycle counts here.
package smbsc_pkg;

   // ==========================================================================
   // Register map
   localparam logic [3:0] SMBSC_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] SMBSC_ADDR_TIMING = 4'h1;
   localparam logic [3:0] SMBSC_ADDR_STATUS = 4'h2;
   localparam logic [3:0] SMBSC_ADDR_TORQUE = 4'h3;
   localparam logic [3:0] SMBSC_ADDR_RUN    = 4'h4;

   // CTRL fields
   localparam int SMBSC_CTRL_BLK_EN   = 0;
   localparam int SMBSC_CTRL_REV_EN   = 1;
   localparam int SMBSC_CTRL_JOG_EN   = 2;
   localparam int SMBSC_CTRL_SLAT_EN  = 3;
   localparam int SMBSC_CTRL_MTYPE_LO = 4;
   localparam int SMBSC_CTRL_SENS_LO  = 8;
   localparam logic [15:0] SMBSC_CTRL_RESET = 16'h0110;

   // Motor type codes 0..6 and sensitivity 1..6
   localparam logic [2:0] SMBSC_MTYPE_MAX = 3'h6;
   localparam logic [2:0] SMBSC_SENS_MIN  = 3'h1;
   localparam logic [2:0] SMBSC_SENS_MAX  = 3'h6;

   // Torque class per motor type, in torque units (Nm)
   localparam logic [7:0] SMBSC_TORQUE_CLASS [7] = '{
      8'h06, 8'h0a, 8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32};

   // ==========================================================================
   // Timing
   localparam int SMBSC_CLK_HZ     = 10_000_000;
   localparam int SMBSC_REV_MS     = 2000;
   localparam int SMBSC_HOLD_MS    = 1000;
   localparam int SMBSC_TICK_MS    = 100;
   localparam int SMBSC_REV_CYC    = SMBSC_CLK_HZ / 1000 * SMBSC_REV_MS;
   localparam int SMBSC_HOLD_CYC   = SMBSC_CLK_HZ / 1000 * SMBSC_HOLD_MS;
   localparam int SMBSC_TICK_CYC   = SMBSC_CLK_HZ / 1000 * SMBSC_TICK_MS;
   localparam logic [15:0] SMBSC_TILT_RESET  = 16'h000a;
   localparam logic [15:0] SMBSC_SLAT_RESET  = 16'h0005;
   localparam logic [15:0] SMBSC_RUN_RESET   = 16'h0096;

   typedef enum logic [5:0] {
      SMBSC_IDLE  = 6'h01,
      SMBSC_JOG   = 6'h02,
      SMBSC_RUN   = 6'h04,
      SMBSC_HELD  = 6'h08,
      SMBSC_REV   = 6'h10,
      SMBSC_SLAT  = 6'h20
   } smbsc_state_e;

endpackage

/* core/smbsc_top.sv */
// Shutter motor drive control: blockage trip, reverse, jog and slat turn.
// Assumes synchronous button and torque inputs and a one-cycle register port.
`timescale 1ns/100ps

module smbsc_top
   import smbsc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        btn_up,
   input  wire logic        btn_down,
   input  wire logic        btn_stop,
   input  wire logic        sun_down,
   input  wire logic [7:0]  torque,
   output logic             motor_up,
   output logic             motor_down,
   output logic             blocked
);

   // =========================================================================
   // State
   typedef struct packed {
      logic [15:0]  ctrl;
      logic [15:0]  tilt;
      logic [15:0]  slat;
      logic [15:0]  run;
      logic [15:0]  rdata;
      smbsc_state_e st;
      logic         dir_dn;
      logic         sun;
      logic         blk;
      logic [24:0]  cyc;
      logic [15:0]  ticks;
      logic [15:0]  limit;
      logic         up_o;
      logic         dn_o;
   } smbsc_regs_s;

   smbsc_regs_s r_q;
   smbsc_regs_s r_d;

   function automatic logic [8:0] trip_level(input logic [2:0] mtype,
                                             input logic [2:0] sens);
      logic [2:0] m;
      logic [2:0] s;
      m = (mtype > SMBSC_MTYPE_MAX) ? SMBSC_MTYPE_MAX : mtype;
      s = (sens < SMBSC_SENS_MIN) ? SMBSC_SENS_MIN :
          (sens > SMBSC_SENS_MAX) ? SMBSC_SENS_MAX : sens;
      // Higher sensitivity lowers the trip above the class torque
      trip_level = {1'b0, SMBSC_TORQUE_CLASS[m]}
                   + 9'(({1'b0, SMBSC_TORQUE_CLASS[m]} *
                         9'(7 - 32'(s))) >> 3);
   endfunction

   logic       blk_en;
   logic       rev_en;
   logic       jog_en;
   logic       slat_en;
   logic [2:0] mtype;
   logic [2:0] sens;
   logic       driving;
   logic       overload;
   logic       tick;
   logic       press_up;
   logic       press_dn;

   assign blk_en  = r_q.ctrl[SMBSC_CTRL_BLK_EN];
   assign rev_en  = r_q.ctrl[SMBSC_CTRL_REV_EN];
   assign jog_en  = r_q.ctrl[SMBSC_CTRL_JOG_EN];
   assign slat_en = r_q.ctrl[SMBSC_CTRL_SLAT_EN];
   assign mtype   = r_q.ctrl[SMBSC_CTRL_MTYPE_LO +: 3];
   assign sens    = r_q.ctrl[SMBSC_CTRL_SENS_LO +: 3];
   assign press_up = btn_up & ~btn_down;
   assign press_dn = btn_down & ~btn_up;
   assign driving  = (r_q.st == SMBSC_JOG) || (r_q.st == SMBSC_RUN)
                     || (r_q.st == SMBSC_HELD);
   assign overload = blk_en && driving
                     && ({1'b0, torque} > trip_level(mtype, sens));
   assign tick     = (r_q.cyc == 25'(SMBSC_TICK_CYC - 1));

   // =========================================================================
   // Next state
   always_comb
   begin
      r_d = r_q;
      r_d.up_o = 1'b0;
      r_d.dn_o = 1'b0;

      if (reg_wr)
      begin
         if (reg_addr == SMBSC_ADDR_CTRL)
            r_d.ctrl = reg_wdata;
         else if (reg_addr == SMBSC_ADDR_TIMING)
            r_d.tilt = reg_wdata;
         else if (reg_addr == SMBSC_ADDR_TORQUE)
            r_d.slat = reg_wdata;
         else if (reg_addr == SMBSC_ADDR_RUN)
            r_d.run = reg_wdata;
      end

      r_d.rdata = 16'h0000;
      if (reg_rd)
      begin
         if (reg_addr == SMBSC_ADDR_CTRL)
            r_d.rdata = r_q.ctrl;
         else if (reg_addr == SMBSC_ADDR_TIMING)
            r_d.rdata = r_q.tilt;
         else if (reg_addr == SMBSC_ADDR_STATUS)
            r_d.rdata = {8'h00, r_q.blk, r_q.dir_dn, r_q.st};
         else if (reg_addr == SMBSC_ADDR_TORQUE)
            r_d.rdata = r_q.slat;
         else if (reg_addr == SMBSC_ADDR_RUN)
            r_d.rdata = r_q.run;
      end
      // Status read clears the blockage flag unless it sets again now
      if (reg_rd && reg_addr == SMBSC_ADDR_STATUS)
         r_d.blk = 1'b0;

      r_d.cyc = tick ? 25'h0000000 : r_q.cyc + 25'h0000001;
      if (tick)
         r_d.ticks = r_q.ticks + 16'h0001;

      case (r_q.st)
         SMBSC_IDLE:
         begin
            r_d.ticks = 16'h0000;
            r_d.cyc   = 25'h0000000;
            r_d.sun   = 1'b0;
            if (press_up || press_dn)
            begin
               r_d.dir_dn = press_dn;
               r_d.st     = jog_en ? SMBSC_JOG : SMBSC_RUN;
               r_d.limit  = r_q.run;
            end
            else if (sun_down)
            begin
               r_d.dir_dn = 1'b1;
               r_d.sun    = 1'b1;
               r_d.st     = SMBSC_RUN;
               r_d.limit  = r_q.run;
            end
         end
         SMBSC_JOG:
         begin
            if (!(btn_up || btn_down))
               r_d.st = SMBSC_IDLE;
            else if (tick && r_q.ticks + 16'h0001 >=
                     r_q.tilt + 16'(SMBSC_HOLD_MS / SMBSC_TICK_MS))
               r_d.st = SMBSC_HELD;
         end
         SMBSC_HELD, SMBSC_RUN:
         begin
            if (btn_stop || (tick && r_q.ticks + 16'h0001 >= r_q.limit))
            begin
               r_d.ticks = 16'h0000;
               r_d.cyc   = 25'h0000000;
               if (r_q.dir_dn && slat_en && !r_q.sun)
                  r_d.st = SMBSC_SLAT;
               else
                  r_d.st = SMBSC_IDLE;
            end
         end
         SMBSC_REV:
         begin
            if (r_q.cyc == 25'(SMBSC_REV_CYC - 1))
               r_d.st = SMBSC_IDLE;
            r_d.ticks = 16'h0000;
         end
         SMBSC_SLAT:
         begin
            if (btn_stop || (tick && r_q.ticks + 16'h0001 >= r_q.slat))
               r_d.st = SMBSC_IDLE;
         end
         default:
            r_d.st = SMBSC_IDLE;
      endcase

      if (r_q.st == SMBSC_REV)
         r_d.cyc = r_q.cyc + 25'h0000001;

      if (overload)
      begin
         r_d.blk   = 1'b1;
         r_d.cyc   = 25'h0000000;
         r_d.ticks = 16'h0000;
         if (rev_en)
         begin
            r_d.st     = SMBSC_REV;
            r_d.dir_dn = ~r_q.dir_dn;
         end
         else
            r_d.st = SMBSC_IDLE;
      end

      if (r_d.st == SMBSC_JOG || r_d.st == SMBSC_RUN ||
          r_d.st == SMBSC_HELD || r_d.st == SMBSC_REV)
      begin
         r_d.up_o = ~r_d.dir_dn;
         r_d.dn_o = r_d.dir_dn;
      end
      else if (r_d.st == SMBSC_SLAT)
         r_d.up_o = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r_q       <= '0;
         r_q.ctrl  <= SMBSC_CTRL_RESET;
         r_q.tilt  <= SMBSC_TILT_RESET;
         r_q.slat  <= SMBSC_SLAT_RESET;
         r_q.run   <= SMBSC_RUN_RESET;
         r_q.st    <= SMBSC_IDLE;
      end
      else
         r_q <= r_d;
   end

   assign reg_rdata  = r_q.rdata;
   assign motor_up   = r_q.up_o;
   assign motor_down = r_q.dn_o;
   assign blocked    = r_q.blk;

   // =========================================================================
   // Checks
   // Trip while driving down with reversing on
   sequence s_trip;
      overload && rev_en && motor_down;
   endsequence

   // Last cycle of the reverse run
   sequence s_rev_last;
      r_q.st == SMBSC_REV && r_q.cyc == 25'(SMBSC_REV_CYC - 1);
   endsequence

   // Any earlier cycle of the reverse run
   sequence s_rev_mid;
      r_q.st == SMBSC_REV && r_q.cyc != 25'(SMBSC_REV_CYC - 1);
   endsequence

   // Sun run still heading down, no trip
   sequence s_sun_run;
      r_q.sun && r_q.st == SMBSC_RUN && !overload;
   endsequence

   // Latched run with time left and no stop
   sequence s_held_go;
      r_q.st == SMBSC_HELD && !btn_stop && !overload
      && (r_q.ticks + 16'h0001 < r_q.limit);
   endsequence

   // Torque beyond twice the class trips at any sensitivity
   sequence s_hard_jam;
      blk_en && driving && mtype <= SMBSC_MTYPE_MAX
      && {1'b0, torque} > {SMBSC_TORQUE_CLASS[mtype], 1'b0};
   endsequence

   // Jog button let go with no trip
   sequence s_jog_off;
      r_q.st == SMBSC_JOG && !btn_up && !btn_down && !overload;
   endsequence

   // Plain stop when reversing is off
   AST_BLK_OFF: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       overload && !rev_en |=> !motor_up && !motor_down)
      else $error("drive stayed on after blockage");

   // Flag never rises while detection is off
   AST_NO_TRIP: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       !blk_en |=> !$rose(blocked))
      else $error("trip while detection off");

   // Reverse runs the other way
   AST_REV_DIR: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_trip |=> motor_up && !motor_down)
      else $error("reverse not opposite");

   // Reverse timer starts from zero
   AST_REV_LEN: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       $rose(r_q.st == SMBSC_REV) |-> r_q.cyc == 25'h0000000)
      else $error("reverse timer not cleared");

   // Drive off once the reverse time is up
   AST_REV_END: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_rev_last |=> !motor_up && !motor_down)
      else $error("reverse length");

   // Reverse holds its course until the timer ends
   AST_REV_NORETRIG: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_rev_mid |=> r_q.st == SMBSC_REV && $stable(motor_up)
       && $stable(motor_down))
      else $error("reverse retriggered");

   // No upward slat turn after a sun run
   AST_SUN_SKIP: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_sun_run |=> !motor_up)
      else $error("slat turn after sun run");

   // Twice the class torque bounds the trip level
   AST_SENS: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_hard_jam |=> blocked)
      else $error("sensitivity order");

   // Jog stops on release
   AST_JOG_REL: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_jog_off |=> !motor_up && !motor_down)
      else $error("jog did not stop");

   // Slat turn drives upward only
   AST_SLAT_UP: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       r_q.st == SMBSC_SLAT |-> motor_up && !motor_down)
      else $error("slat turn direction");

   // Latched run keeps going after release
   AST_HELD_RUN: assert property
      (@(posedge ref_clk) disable iff (!reset_n)
       s_held_go |=> motor_up || motor_down)
      else $error("latched run stopped early");

endmodule

/* tb/smbsc_motor_model.sv */
// Tubular motor model: returns torque while the drive is on.
// Assumes the bench sets jam, jam level and running torque.
`timescale 1ns/100ps

module smbsc_motor_model
(
   input  wire logic       ref_clk,
   input  wire logic       motor_up,
   input  wire logic       motor_down,
   input  wire logic       jam,
   input  wire logic [7:0] jam_level,
   input  wire logic [7:0] run_level,
   output logic      [7:0] torque
);
   // ==========================================================================
   // Torque
   // No drive, no torque; a jam loads whichever way it turns
   always_ff @(posedge ref_clk)
      torque <= !(motor_up || motor_down) ? 8'h00 :
                jam ? jam_level : run_level;
endmodule

/* tb/smbsc_top_test.sv */
// Self-checking bench for the shutter motor control block.
// Assumes smbsc_pkg and smbsc_top are compiled first.
`timescale 1ns/100ps

module smbsc_top_test;
   import smbsc_pkg::*;
   logic        ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, ctrl;
   logic        btn_up = 0, btn_down = 0, btn_stop = 0, sun_down = 0;
   logic        jam = 0, rd_d = 0, motor_up, motor_down, blocked;
   logic [7:0]  torque, jam_level = 8'hff, run_level = 8'h00;
   logic [15:0] exp_q[$];
   int          n_errors = 0, n_tests = 0, seed = 17924;

   always #50 ref_clk = ~ref_clk;

   smbsc_top u_smbsc_top(.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .btn_up(btn_up),
      .btn_down(btn_down), .btn_stop(btn_stop), .sun_down(sun_down),
      .torque(torque), .motor_up(motor_up), .motor_down(motor_down),
      .blocked(blocked));
   smbsc_motor_model u_smbsc_motor_model(.ref_clk(ref_clk),
      .motor_up(motor_up), .motor_down(motor_down), .jam(jam),
      .jam_level(jam_level), .run_level(run_level), .torque(torque));

   // ==========================================================================
   // Checking
   task check(string name, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk)
   begin
      if (rd_d)
         check("reg_rdata", exp_q.pop_front(), reg_rdata);
      rd_d <= reg_rd;
   end

   task print_verdict;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================================
   // Stimulus tasks
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task wr(logic [3:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(logic [3:0] a, logic [15:0] x);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task motor(logic up, logic dn);
      @(negedge ref_clk);
      check("motor", {14'h0, up, dn}, {14'h0, motor_up, motor_down});
      @(posedge ref_clk);
   endtask

   task run_down;
      btn_down <= 1'b1;
      cyc(3);
      btn_down <= 1'b0;
      cyc(2);
   endtask

   task stop_press;
      btn_stop <= 1'b1;
      cyc(1);
      btn_stop <= 1'b0;
      cyc(3);
   endtask

   task do_reset;
      reset_n <= 1'b0;
      jam <= 1'b0;
      cyc(5);
      reset_n <= 1'b1;
   endtask

   // ==========================================================================
   // Main sequence
   initial
   begin
      cyc(5);
      reset_n <= 1'b1;
      run_level <= 8'($unsigned($random(seed)) % 4);
      rd(SMBSC_ADDR_CTRL, SMBSC_CTRL_RESET);
      rd(SMBSC_ADDR_TIMING, SMBSC_TILT_RESET);
      rd(SMBSC_ADDR_TORQUE, SMBSC_SLAT_RESET);
      rd(SMBSC_ADDR_RUN, SMBSC_RUN_RESET);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000);
      repeat (4)
      begin
         ctrl = 16'h0000;
         ctrl[3:0] = 4'($random(seed));
         ctrl[6:4] = 3'($unsigned($random(seed)) % 7);
         ctrl[10:8] = 3'(1 + $unsigned($random(seed)) % 6);
         wr(SMBSC_ADDR_CTRL, ctrl);
         rd(SMBSC_ADDR_CTRL, ctrl);
      end
      wr(SMBSC_ADDR_CTRL, 16'h0601);
      run_down;
      motor(1'b0, 1'b1);
      jam <= 1'b1;
      cyc(4);
      motor(1'b0, 1'b0);
      check("blocked", 16'h1, {15'h0, blocked});
      rd(SMBSC_ADDR_STATUS, 16'h00c1);
      cyc(3);
      check("blocked", 16'h0, {15'h0, blocked});
      jam <= 1'b0;
      wr(SMBSC_ADDR_CTRL, 16'h0600);
      run_down;
      jam <= 1'b1;
      cyc(4);
      motor(1'b0, 1'b1);
      stop_press;
      jam <= 1'b0;
      jam_level <= 8'h40;
      wr(SMBSC_ADDR_CTRL, 16'h0161);
      run_down;
      jam <= 1'b1;
      cyc(4);
      motor(1'b0, 1'b1);
      wr(SMBSC_ADDR_CTRL, 16'h0601);
      cyc(4);
      motor(1'b0, 1'b0);
      jam <= 1'b0;
      jam_level <= 8'hff;
      rd(SMBSC_ADDR_STATUS, 16'h00c1);
      wr(SMBSC_ADDR_CTRL, 16'h0603);
      run_down;
      jam <= 1'b1;
      cyc(4);
      motor(1'b1, 1'b0);
      cyc(100);
      motor(1'b1, 1'b0);
      do_reset;
      wr(SMBSC_ADDR_CTRL, 16'h0108);
      run_down;
      stop_press;
      motor(1'b1, 1'b0);
      do_reset;
      wr(SMBSC_ADDR_CTRL, 16'h0108);
      sun_down <= 1'b1;
      cyc(3);
      motor(1'b0, 1'b1);
      sun_down <= 1'b0;
      stop_press;
      motor(1'b0, 1'b0);
      do_reset;
      wr(SMBSC_ADDR_CTRL, 16'h0104);
      btn_up <= 1'b1;
      cyc(2);
      motor(1'b1, 1'b0);
      btn_up <= 1'b0;
      cyc(10);
      motor(1'b0, 1'b0);
      print_verdict;
   end

   initial
   begin
      cyc(50000);
      n_errors++;
      print_verdict;
   end
endmodule
